// ---- hw/code_xlate.sv ----
`timescale 1ns/100ps
module code_xlate
(
    // mode
    input  wire logic                        tty,
    // characters in
    input  wire logic [scan_pkg::CHAR_W-1:0] host_ch,
    input  wire logic [scan_pkg::CHAR_W-1:0] term_ch,
    // characters out
    output logic      [scan_pkg::CHAR_W-1:0] to_term,
    output logic      [scan_pkg::CHAR_W-1:0] to_host
);

    wire [scan_pkg::CHAR_W-1:0] host_as_baudot;
    wire [scan_pkg::CHAR_W-1:0] baudot_as_host;

    // five code bits are mirrored, shift flag rides on top; mapping is its own inverse
    genvar b;
    generate
        for (b = 0; b < scan_pkg::FIGS_BIT; b = b + 1)
        begin : g_bit
            assign host_as_baudot[b] = host_ch[scan_pkg::FIGS_BIT-1-b];
            assign baudot_as_host[b] = term_ch[scan_pkg::FIGS_BIT-1-b];
        end
    endgenerate
    assign host_as_baudot[scan_pkg::FIGS_BIT] = host_ch[scan_pkg::FIGS_BIT];
    assign baudot_as_host[scan_pkg::FIGS_BIT] = term_ch[scan_pkg::FIGS_BIT];

    assign to_term = tty ? host_as_baudot : host_ch;
    assign to_host = tty ? baudot_as_host : term_ch;

endmodule // code_xlate

// ---- hw/scan_pkg.sv ----
package scan_pkg;

    // scanner geometry
    localparam int NCH    = 15;
    localparam int CH_W   = 4;
    localparam int CHAR_W = 6;
    localparam int FIGS_BIT = 5;

    // two-bit terminal status codes
    localparam logic [1:0] ST_BUSY    = 2'h0;
    localparam logic [1:0] ST_IN_RDY  = 2'h1;
    localparam logic [1:0] ST_OUT_RDY = 2'h2;
    localparam logic [1:0] ST_NOT_RDY = 2'h3;

    // end of message as seen by the host
    localparam logic [CHAR_W-1:0] GROUP_MARK = 6'h3F;

    // reset values
    localparam logic [CH_W-1:0] ADDR_RST   = 4'h0;
    localparam logic [1:0]      STATUS_RST = ST_NOT_RDY;

    // channel-to-channel scan time, longest
    localparam int STEP_TIME_NS  = 220000;
    localparam int CLK_PERIOD_NS = 8;
    localparam int STEP_CYCLES   = STEP_TIME_NS / CLK_PERIOD_NS;

    typedef struct packed {
        logic [NCH-1:0] call;
        logic [NCH-1:0] buf_busy;
        logic [NCH-1:0] msg_in;
        logic [NCH-1:0] out_done;
        logic [NCH-1:0] is_tty;
    } term_lines_s;

    typedef struct packed {
        logic [CHAR_W-1:0] ch;
        logic              valid;
        logic              eom;
    } char_s;

    typedef enum logic [1:0] {
        SC_STEP = 2'b01,
        SC_HOLD = 2'b10
    } scan_e;

endpackage

// ---- hw/terminal_scanner_control.sv ----
// Notes on behaviour
// - up to fifteen terminals of any type mix sit on channels 0 to 14 reached by the scanner.
// - the host moves characters only while it signals a buffer load or unload; otherwise the block runs alone.
// - characters are translated both ways between the host six-bit code and Baudot.
// - translation applies only while a teletype terminal is addressed; others pass unchanged.
// - each terminal is seen as busy, input ready, output ready or not ready.
// - no character moves to or from an addressed terminal that is busy.
// - a terminal is busy while a foreign call is on its net or its buffer is being exchanged.
// - a terminal is input ready once its message is complete, marked by end of message.
// - the end of message character reaches the host as the group mark code.
// - a terminal is output ready once it has sent its buffer without meeting a group mark.
// - the interrupt stands from the step onto a terminal found input or output ready until the host transfer ends.
// - the scanner steps one way, prefers output ready terminals, and holds a ready channel until the host transfer ends, any other at most 220 us.
`timescale 1ns/100ps
module terminal_scanner_control
#(
    parameter int unsigned STEP_CYCLES = scan_pkg::STEP_CYCLES
)
(
    // clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst,
    // terminal pins
    input  wire scan_pkg::term_lines_s         term_lines,
    input  wire scan_pkg::char_s               term_rx,
    output scan_pkg::char_s                    term_tx,
    // host side
    input  wire logic                          host_xfer,
    input  wire scan_pkg::char_s               host_tx,
    output scan_pkg::char_s                    host_rx,
    output logic                               ready_irq,
    // scanner state
    output logic      [scan_pkg::CH_W-1:0]     scan_addr,
    output logic      [1:0]                    scan_status,
    output logic                               scan_tty
);

    localparam int CNT_W = $clog2(STEP_CYCLES + 1);
    localparam logic [CNT_W-1:0] DWELL_LAST = CNT_W'(STEP_CYCLES - 1);

    // pin synchronisers
    scan_pkg::term_lines_s lines_s1_q, lines_q;
    scan_pkg::char_s       rx_s1_q, rx_q;
    logic                  rx_valid_prev_q;

    always_ff @(posedge clk)
    begin
        lines_s1_q      <= term_lines;
        lines_q         <= lines_s1_q;
        rx_s1_q         <= term_rx;
        rx_q            <= rx_s1_q;
        rx_valid_prev_q <= rst ? 1'b0 : rx_q.valid;
    end

    // per-channel status decode
    logic [1:0]               ch_state [scan_pkg::NCH];
    logic [scan_pkg::NCH-1:0] out_rdy;

    genvar i;
    generate
        for (i = 0; i < scan_pkg::NCH; i = i + 1)
        begin : g_ch
            wire busy = lines_q.call[i] | lines_q.buf_busy[i];
            assign ch_state[i] = busy                ? scan_pkg::ST_BUSY    :
                                 lines_q.msg_in[i]   ? scan_pkg::ST_IN_RDY  :
                                 lines_q.out_done[i] ? scan_pkg::ST_OUT_RDY :
                                                       scan_pkg::ST_NOT_RDY;
            assign out_rdy[i] = (ch_state[i] == scan_pkg::ST_OUT_RDY);
        end
    endgenerate

    // registered state
    scan_pkg::scan_e            state_q, state_d;
    logic [scan_pkg::CH_W-1:0]  addr_q, addr_d;
    logic [1:0]                 status_q, status_d;
    logic                       tty_q, tty_d;
    logic                       irq_q;
    logic [CNT_W-1:0]           dwell_q, dwell_d;
    logic                       xfer_prev_q;
    scan_pkg::char_s            host_rx_q, host_rx_d, term_tx_q, term_tx_d;

    // next channel: first output ready one ahead, else simply the next one
    logic [scan_pkg::CH_W-1:0]  next_addr;
    always_comb
    begin
        logic [4:0] idx;
        idx       = 5'h0;
        next_addr = (addr_q == 4'(scan_pkg::NCH - 1)) ? 4'h0 : addr_q + 4'h1;
        for (int off = scan_pkg::NCH - 1; off >= 1; off--)
        begin
            idx = {1'b0, addr_q} + 5'(off);
            if (idx >= 5'(scan_pkg::NCH))
                idx = idx - 5'(scan_pkg::NCH);
            if (out_rdy[idx[3:0]])
                next_addr = idx[3:0];
        end
    end

    wire [1:0] next_state_code = ch_state[next_addr];
    wire       next_ready      = (next_state_code == scan_pkg::ST_IN_RDY) ||
                                 (next_state_code == scan_pkg::ST_OUT_RDY);
    wire       dwell_done      = (dwell_q == DWELL_LAST);
    wire       xfer_done       = xfer_prev_q & ~host_xfer;
    wire       addr_busy       = (ch_state[addr_q] == scan_pkg::ST_BUSY);
    wire       path_open       = (state_q == scan_pkg::SC_HOLD) & host_xfer & ~addr_busy;
    wire       rx_edge         = rx_q.valid & ~rx_valid_prev_q;
    wire       step            = (state_q == scan_pkg::SC_STEP) ? dwell_done : xfer_done;

    wire [scan_pkg::CHAR_W-1:0] xl_to_term;
    wire [scan_pkg::CHAR_W-1:0] xl_to_host;

    code_xlate code_xlate_inst
    (
        .tty     (tty_q),
        .host_ch (host_tx.ch),
        .term_ch (rx_q.ch),
        .to_term (xl_to_term),
        .to_host (xl_to_host)
    );

    always_comb
    begin
        state_d  = state_q;
        addr_d   = addr_q;
        status_d = status_q;
        tty_d    = tty_q;
        dwell_d  = (state_q == scan_pkg::SC_STEP) ? dwell_q + CNT_W'(1) : '0;
        case (state_q)
            scan_pkg::SC_STEP, scan_pkg::SC_HOLD:
            begin
                if (step)
                begin
                    addr_d   = next_addr;
                    status_d = next_state_code;
                    tty_d    = lines_q.is_tty[next_addr];
                    dwell_d  = '0;
                    state_d  = next_ready ? scan_pkg::SC_HOLD : scan_pkg::SC_STEP;
                end
            end
            default:
            begin
                state_d = scan_pkg::SC_STEP;
                dwell_d = '0;
            end
        endcase
    end

    // character paths, open only under host control to a non-busy terminal
    always_comb
    begin
        host_rx_d       = '0;
        term_tx_d       = '0;
        host_rx_d.valid = path_open & rx_edge;
        host_rx_d.eom   = rx_q.eom;
        host_rx_d.ch    = rx_q.eom ? scan_pkg::GROUP_MARK : xl_to_host;
        term_tx_d.valid = path_open & host_tx.valid;
        term_tx_d.ch    = xl_to_term;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_q     <= scan_pkg::SC_STEP;
            addr_q      <= scan_pkg::ADDR_RST;
            status_q    <= scan_pkg::STATUS_RST;
            tty_q       <= 1'b0;
            irq_q       <= 1'b0;
            dwell_q     <= '0;
            xfer_prev_q <= 1'b0;
            host_rx_q   <= '0;
            term_tx_q   <= '0;
        end
        else
        begin
            state_q     <= state_d;
            addr_q      <= addr_d;
            status_q    <= status_d;
            tty_q       <= tty_d;
            irq_q       <= (state_d == scan_pkg::SC_HOLD);
            dwell_q     <= dwell_d;
            xfer_prev_q <= host_xfer;
            host_rx_q   <= host_rx_d;
            term_tx_q   <= term_tx_d;
        end
    end

    assign scan_addr   = addr_q;
    assign scan_status = status_q;
    assign scan_tty    = tty_q;
    assign ready_irq   = irq_q;
    assign host_rx     = host_rx_q;
    assign term_tx     = term_tx_q;

    a_addr_range: assert property (@(posedge clk) disable iff (rst) addr_q < 4'hF)
        else $error("scanner address out of range");
    a_irq_ready: assert property (@(posedge clk) disable iff (rst)
        irq_q |-> (status_q == scan_pkg::ST_IN_RDY || status_q == scan_pkg::ST_OUT_RDY))
        else $error("interrupt without ready terminal");
    a_status_hold: assert property (@(posedge clk) disable iff (rst)
        ##1 $stable(addr_q) |-> $stable(status_q))
        else $error("status changed while addressed");
    a_dwell_bound: assert property (@(posedge clk) disable iff (rst)
        dwell_q <= DWELL_LAST)
        else $error("channel dwell too long");
    a_no_busy_xfer: assert property (@(posedge clk) disable iff (rst)
        (host_rx_q.valid || term_tx_q.valid) |-> $past(!addr_busy))
        else $error("character moved to busy terminal");
    a_host_only: assert property (@(posedge clk) disable iff (rst)
        (host_rx_q.valid || term_tx_q.valid) |-> $past(host_xfer))
        else $error("character moved without host control");
    a_group_mark: assert property (@(posedge clk) disable iff (rst)
        host_rx_q.valid && host_rx_q.eom |-> host_rx_q.ch == scan_pkg::GROUP_MARK)
        else $error("end of message not sent as group mark");
    a_plain_pass: assert property (@(posedge clk) disable iff (rst)
        term_tx_q.valid && !tty_q |-> term_tx_q.ch == $past(host_tx.ch))
        else $error("non teletype character altered");
    a_tty_mirror: assert property (@(posedge clk) disable iff (rst)
        term_tx_q.valid && tty_q |-> term_tx_q.ch[0] == $past(host_tx.ch[scan_pkg::FIGS_BIT-1]))
        else $error("teletype character not translated");
    a_step_on_done: assert property (@(posedge clk) disable iff (rst)
        (state_q == scan_pkg::SC_STEP) && dwell_done |=> addr_q != $past(addr_q))
        else $error("scanner failed to step");

    c_irq_rise: cover property (@(posedge clk) disable iff (rst) $rose(irq_q));
    c_eom_pass: cover property (@(posedge clk) disable iff (rst) host_rx_q.valid && host_rx_q.eom);
    c_tty_send: cover property (@(posedge clk) disable iff (rst) term_tx_q.valid && tty_q);
    c_prio_skip: cover property (@(posedge clk) disable iff (rst)
        step && out_rdy != '0 && next_addr != ((addr_q == 4'hE) ? 4'h0 : addr_q + 4'h1));

endmodule // terminal_scanner_control

// ---- tb/term_model.sv ----
`timescale 1ns/100ps
module term_model
(
    // clock
    input  wire logic                  clk,
    // bench controls
    input  wire scan_pkg::term_lines_s cfg,
    input  wire logic                  go,
    input  wire logic [5:0]            ch,
    input  wire logic                  eom,
    // terminal pins
    output scan_pkg::term_lines_s      term_lines,
    output scan_pkg::char_s            term_rx
);
    logic sent = 1'b0;

    // status levels straight from the bench's terminal table
    assign term_lines = cfg;

    initial
    begin
        term_rx = '0;
        forever
        begin
            // go is sampled on the rising edge, away from the bench's falling-edge drive
            @(posedge clk);
            if (go && !sent)
            begin
                // data settles 3 clocks before valid, low 3 clocks after
                @(negedge clk);
                term_rx.ch  = ch;
                term_rx.eom = eom;
                repeat (3) @(negedge clk);
                term_rx.valid = 1'b1;
                repeat (4) @(negedge clk);
                term_rx.valid = 1'b0;
                repeat (3) @(negedge clk);
                sent = 1'b1;
            end
            else
            begin
                if (!go)
                    sent = 1'b0;
                @(negedge clk);
                // idle data churns so a stale char never passes
                term_rx.ch  = ~term_rx.ch;
                term_rx.eom = ~term_rx.eom;
            end
        end
    end
endmodule // term_model

// ---- tb/terminal_scanner_control_tb.sv ----
`timescale 1ns/100ps
module terminal_scanner_control_tb;
    localparam int STEP = 8;
    logic                  clk       = 1'b0;
    logic                  rst       = 1'b1;
    logic                  host_xfer = 1'b0;
    logic                  go        = 1'b0;
    logic [5:0]            rx_ch     = 6'h00;
    logic                  rx_eom    = 1'b0;
    logic [5:0]            r;
    scan_pkg::char_s       host_tx   = '0;
    scan_pkg::term_lines_s cfg       = '0;
    scan_pkg::term_lines_s term_lines;
    scan_pkg::char_s       term_rx, term_tx, host_rx;
    logic                  ready_irq, scan_tty;
    logic [3:0]            scan_addr;
    logic [1:0]            scan_status;
    int                    mismatches   = 0;
    int                    total_checks = 0;
    int                    seed         = 32'h641e;
    int                    cur          = 0;
    int                    model_addr   = 0;
    logic [5:0]            exp_q [$];
    int                    n;

    always #4 clk = ~clk;

    term_model term_model_inst (.clk(clk), .cfg(cfg), .go(go), .ch(rx_ch), .eom(rx_eom),
        .term_lines(term_lines), .term_rx(term_rx));

    terminal_scanner_control #(.STEP_CYCLES(STEP)) terminal_scanner_control_inst (
        .clk(clk), .rst(rst), .term_lines(term_lines), .term_rx(term_rx),
        .term_tx(term_tx), .host_xfer(host_xfer), .host_tx(host_tx), .host_rx(host_rx),
        .ready_irq(ready_irq), .scan_addr(scan_addr), .scan_status(scan_status),
        .scan_tty(scan_tty));

    task conclude;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task timeout;
        mismatches++;
        $display("BAD at %0t: wait ran out", $time);
        conclude();
    endtask

    function logic [1:0] st(input int c);
        if (cfg.call[c] | cfg.buf_busy[c]) return scan_pkg::ST_BUSY;
        if (cfg.msg_in[c]) return scan_pkg::ST_IN_RDY;
        if (cfg.out_done[c]) return scan_pkg::ST_OUT_RDY;
        return scan_pkg::ST_NOT_RDY;
    endfunction

    function int nxt(input int a);
        for (int i = 1; i < 15; i++)
            if (st((a + i) % 15) == scan_pkg::ST_OUT_RDY) return (a + i) % 15;
        return (a + 1) % 15;
    endfunction

    // teletype mapping: low five bits reversed, shift bit carried
    function logic [5:0] xl(input logic [5:0] h, input logic t);
        return t ? {h[5], h[0], h[1], h[2], h[3], h[4]} : h;
    endfunction

    task mv;
        int   e;
        logic rdy;
        e   = nxt(model_addr);
        rdy = st(e) inside {scan_pkg::ST_IN_RDY, scan_pkg::ST_OUT_RDY};
        n   = 0;
        while (scan_addr == model_addr)
        begin
            @(negedge clk);
            n++;
            if (n > STEP + 2) timeout();
        end
        check(8'(n <= STEP + 1), 8'h01);
        check(8'(scan_addr), 8'(e));
        check(8'(scan_status), 8'(st(e)));
        check(8'(scan_tty), 8'(cfg.is_tty[e]));
        check(8'(ready_irq), 8'(rdy));
        model_addr = e;
    endtask

    task h2t(input logic [5:0] c, input logic p);
        if (p) exp_q.push_back(xl(c, cfg.is_tty[cur]));
        host_tx = '{ch: c, valid: 1'b1, eom: 1'b0};
        @(negedge clk);
        host_tx.valid = 1'b0;
        for (n = 0; n < 3 && term_tx.valid !== 1'b1; n++) @(negedge clk);
        check(8'(term_tx.valid), 8'(p));
        if (p) check(8'(term_tx.ch), 8'(exp_q.pop_front()));
        // one idle cycle keeps back-to-back calls from rewriting valid in one step
        @(negedge clk);
        check(8'(term_tx.valid), 8'h00);
    endtask

    task t2h(input logic [5:0] c, input logic e);
        exp_q.push_back(e ? scan_pkg::GROUP_MARK : xl(c, cfg.is_tty[cur]));
        rx_ch  = c;
        rx_eom = e;
        go     = 1'b1;
        n      = 0;
        while (host_rx.valid !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 12) timeout();
        end
        check(8'(host_rx.ch), 8'(exp_q.pop_front()));
        check(8'(host_rx.eom), 8'(e));
        repeat (8) @(negedge clk);
        go = 1'b0;
        @(negedge clk);
    endtask

    task serve(input int c, input logic tty, input logic inp);
        cur           = c;
        cfg.is_tty[c] = tty;
        if (inp) cfg.msg_in[c] = 1'b1;
        else cfg.out_done[c] = 1'b1;
        for (int k = 0; k < 16 && model_addr != c; k++) mv();
        repeat (2 * STEP) @(negedge clk);
        check(8'(scan_addr), 8'(c));
        check(8'(ready_irq), 8'h01);
        r = 6'($random(seed));
        if (inp)
        begin
            host_xfer = 1'b1;
            t2h(r, 1'b0);
            t2h(r, 1'b1);
        end
        else
        begin
            h2t(r, 1'b0);
            host_xfer = 1'b1;
            h2t(r, 1'b1);
            h2t(~r, 1'b1);
            cfg.call[c] = 1'b1;
            repeat (3) @(negedge clk);
            h2t(r, 1'b0);
            cfg.call[c] = 1'b0;
            repeat (3) @(negedge clk);
            h2t(scan_pkg::GROUP_MARK, 1'b1);
        end
        cfg.msg_in[c]   = 1'b0;
        cfg.out_done[c] = 1'b0;
        @(negedge clk);
        host_xfer = 1'b0;
        mv();
        $display("test done: serve %0d", c);
    endtask

    initial
    begin
        cfg.is_tty      = 15'($random(seed));
        cfg.call[3]     = 1'b1;
        cfg.buf_busy[5] = 1'b1;
        repeat (8) @(negedge clk);
        check(8'(scan_addr), 8'h00);
        check(8'(scan_status), 8'(scan_pkg::STATUS_RST));
        check(8'(ready_irq), 8'h00);
        rst = 1'b0;
        repeat (20) mv();
        $display("test done: scan order");
        serve(9, 1'b1, 1'b0);
        serve(2, 1'b0, 1'b0);
        serve(7, 1'b1, 1'b1);
        serve(12, 1'b0, 1'b1);
        rst        = 1'b1;
        model_addr = 0;
        repeat (3) @(negedge clk);
        check(8'(scan_addr), 8'h00);
        check(8'(host_rx.valid), 8'h00);
        rst = 1'b0;
        repeat (4) mv();
        $display("test done: second reset");
        conclude();
    end
endmodule // terminal_scanner_control_tb
